// ### include/vism_pkg.sv
// Constants and types shared by the vectored interrupt source mux
package vism_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_SYS     = 16;
  localparam int NUM_IRQ     = 32;
  localparam int NUM_EXC     = 48;
  localparam int DMA_HALF    = 16;
  localparam int PRIO_W      = 3;
  localparam int RANK_W      = 5;
  localparam int STACK_WORDS = 8;
  localparam int CNT_W       = 3;
  // ==========================================================
  // Exception numbers
  localparam logic [5:0] EXC_NONE  = 6'h00;
  localparam logic [5:0] EXC_RESET = 6'h01;
  localparam logic [5:0] EXC_NMI   = 6'h02;
  localparam logic [5:0] EXC_HARD  = 6'h03;
  localparam logic [5:0] EXC_MEM   = 6'h04;
  localparam logic [5:0] EXC_BUS   = 6'h05;
  localparam logic [5:0] EXC_USAGE = 6'h06;
  localparam logic [5:0] EXC_SUPV  = 6'h0b;
  localparam logic [5:0] EXC_DEBUG = 6'h0c;
  localparam logic [5:0] EXC_DSR   = 6'h0e;
  localparam logic [5:0] EXC_TICK  = 6'h0f;
  // ==========================================================
  // Vector table offsets
  localparam logic [9:0] OFS_SP    = 10'h000;
  localparam logic [9:0] OFS_RESET = 10'h004;
  // ==========================================================
  // Reserved numbers and fixed-function lines
  localparam logic [47:0] RSV_EXC_MASK   = 48'h0000_0000_2781;
  localparam logic [31:0] FIXED_RSV_MASK = 32'h0400_0004;
  // ==========================================================
  // Priority ranks, lower wins; last stack word count
  localparam logic [4:0] RANK_RESET     = 5'h00;
  localparam logic [4:0] RANK_NMI       = 5'h01;
  localparam logic [4:0] RANK_HARD      = 5'h02;
  localparam logic [4:0] RANK_PROG_BASE = 5'h08;
  localparam logic [4:0] RANK_THREAD    = 5'h1f;
  localparam logic [2:0] CNT_LAST       = 3'h7;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SRC_FIXED  = 2'h0,
    SRC_DMA    = 2'h1,
    SRC_FABRIC = 2'h2,
    SRC_NONE   = 2'h3
  } vism_src_t;

  typedef enum logic [7:0] {
    ST_BOOT_SP = 8'h01,
    ST_BOOT_PC = 8'h02,
    ST_IDLE    = 8'h04,
    ST_STACK   = 8'h08,
    ST_VECTOR  = 8'h10,
    ST_HANDLER = 8'h20,
    ST_RETCHK  = 8'h40,
    ST_UNSTACK = 8'h80
  } vism_state_t;
endpackage : vism_pkg

// ### sim/vectored_interrupt_source_mux_bench.sv
// Self-checking bench for the vectored interrupt source mux
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_source_mux_bench;
  import vism_pkg::*;
  logic        clk, nrst, exc_return, vec_valid, vec_is_sp, stack_push, stack_pop, lsp;
  logic [31:0] fixed_irq, fabric_irq, en;
  logic [15:0] dma_lo, dma_hi;
  logic [63:0] src_sel;
  logic [95:0] irq_prio;
  logic [8:0]  ev;
  logic [63:0] nmi_pins;
  logic [5:0]  nmi_sel;
  logic [1:0]  pgrp;
  logic        nmi_connect;
  logic [2:0]  fault_en, stack_word;
  logic [9:0]  vec_offset, lofs;
  logic [5:0]  vec_exc_num, active_exc, lnum;
  int          n_fail = 0, num_checks = 0, nv = 0, np = 0, ws = 0;
  vism_top dut (.clk(clk), .nrst(nrst), .fixed_irq(fixed_irq), .dma_term_out_low(dma_lo),
    .dma_term_out_high(dma_hi), .fabric_irq(fabric_irq), .src_sel(src_sel), .irq_enable(en),
    .irq_prio(irq_prio), .sys_prio(21'h0), .prio_group(pgrp), .fault_en(fault_en),
    .memory_mgmt_fault_evt(ev[0]), .bus_err_prefetch(ev[1]), .bus_err_data(ev[2]),
    .usage_undef_instr(ev[3]), .usage_state_exit(ev[4]), .supervisor_call_req(ev[5]),
    .deferred_service_request_set(ev[6]), .system_tick_timer_evt(ev[7]), .debug_mon_req(ev[8]),
    .nmi_pins(nmi_pins), .nmi_pin_sel(nmi_sel), .nmi_connect(nmi_connect), .exc_return(exc_return),
    .vec_valid(vec_valid), .vec_is_sp(vec_is_sp), .vec_offset(vec_offset), .vec_exc_num(vec_exc_num),
    .stack_push(stack_push), .stack_pop(stack_pop), .stack_word(stack_word), .active_exc(active_exc));
  vism_core_model core (.clk(clk), .nrst(nrst), .vec_valid(vec_valid), .vec_is_sp(vec_is_sp),
    .vec_exc_num(vec_exc_num), .exc_return(exc_return));
  // ==========
  // Fetch and push monitor
  always @(posedge clk)
  begin
    if (vec_valid === 1'b1)
    begin
      nv++;
      lnum = vec_exc_num;
      lofs = vec_offset;
      lsp  = vec_is_sp;
    end
    if (stack_push === 1'b1)
      np++;
    if (stack_push === 1'b1 || stack_pop === 1'b1)
    begin
      chk("word", stack_word, ws);
      ws = (ws + 1) % 8;
    end
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic step;
    @(posedge clk);
    #1;
  endtask : step
  task automatic tmo(input bit bad);
    if (bad)
    begin
      n_fail++;
      report_and_stop();
    end
  endtask : tmo
  task automatic wait_vec(input logic [5:0] num, input int pu);
    int n0, p0, k;
    n0 = nv;
    p0 = np;
    for (k = 0; k < 300 && nv == n0; k++)
      step();
    tmo(nv == n0);
    chk("sp", lsp, num == 6'h00);
    chk("offset", lofs, {num, 2'h0});
    if (num != 6'h00)
      chk("num", lnum, num);
    if (num > 6'h01)
      chk("active", active_exc, num);
    if (pu >= 0)
      chk("push", np - p0, pu);
  endtask : wait_vec
  task automatic wait_idle;
    int k, q;
    q = 0;
    for (k = 0; k < 300 && q < 12; k++)
    begin
      step();
      q = (active_exc === 6'h00 && stack_pop === 1'b0) ? q + 1 : 0;
    end
    tmo(q < 12);
    chk("pairing", ws, 0);
  endtask : wait_idle
  // ==========
  // Scenarios
  task automatic t_src;
    int n0;
    src_sel = {32{2'h2}};
    fabric_irq[5] = 1'b1;
    step();
    fabric_irq = '0;
    wait_vec(6'h15, 8);
    wait_idle();
    src_sel = {32{2'h1}};
    dma_hi[3] = 1'b1;
    step();
    dma_hi = '0;
    wait_vec(6'h23, 8);
    wait_idle();
    src_sel = '0;
    n0 = nv;
    fixed_irq = 32'h8400_0004;
    step();
    fixed_irq = '0;
    wait_vec(6'h2f, 8);
    wait_idle();
    chk("count", nv - n0, 1);
    $display("source select done");
  endtask : t_src
  task automatic t_prio;
    src_sel = {32{2'h2}};
    fabric_irq = 32'h0000_0088;
    step();
    fabric_irq = '0;
    wait_vec(6'h13, 8);
    wait_vec(6'h17, 0);
    wait_idle();
    irq_prio[30 +: 3] = 3'h1;
    irq_prio[12 +: 3] = 3'h2;
    fabric_irq = 32'h0000_0410;
    step();
    fabric_irq = '0;
    wait_vec(6'h1a, 8);
    wait_vec(6'h14, 0);
    wait_idle();
    pgrp = 2'h1;
    irq_prio[30 +: 3] = 3'h2;
    irq_prio[12 +: 3] = 3'h3;
    fabric_irq = 32'h0000_0010;
    step();
    fabric_irq = '0;
    wait_vec(6'h14, 8);
    fabric_irq = 32'h0000_0400;
    step();
    fabric_irq = '0;
    wait_vec(6'h1a, 0);
    wait_idle();
    pgrp = 2'h0;
    irq_prio = '0;
    $display("priority done");
  endtask : t_prio
  task automatic t_sys;
    logic [5:0] tbl [9] = '{6'h04, 6'h05, 6'h05, 6'h06, 6'h06, 6'h0b, 6'h0e, 6'h0f, 6'h0c};
    for (int j = 0; j < 2; j++)
      for (int i = 0; i < 9; i++)
      begin
        fault_en = j ? 3'h7 : 3'h0;
        ev[i] = 1'b1;
        step();
        ev = '0;
        wait_vec((j == 0 && i < 5) ? 6'h03 : tbl[i], 8);
        wait_idle();
      end
    $display("system exceptions done");
  endtask : t_sys
  task automatic t_nmi;
    int n0;
    n0 = nv;
    nmi_pins[9] = 1'b1;
    step();
    nmi_pins = '0;
    wait_idle();
    chk("nmi off", nv - n0, 0);
    nmi_connect = 1'b1;
    nmi_sel = 6'h09;
    step();
    nmi_pins[9] = 1'b1;
    step();
    nmi_pins = '0;
    wait_vec(6'h02, 8);
    wait_idle();
    nmi_connect = 1'b0;
    $display("nmi done");
  endtask : t_nmi
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    {nrst, fixed_irq, fabric_irq, dma_lo, dma_hi, src_sel, irq_prio, ev, fault_en} = '0;
    {nmi_pins, nmi_sel, pgrp, nmi_connect} = '0;
    en = 32'hffff_ffff;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    wait_vec(6'h00, -1);
    wait_vec(6'h01, -1);
    t_src();
    t_prio();
    t_sys();
    t_nmi();
    report_and_stop();
  end
endmodule : vectored_interrupt_source_mux_bench
`default_nettype wire

// ### sim/vism_core_model.sv
// Core model: runs each handler except reset briefly, then returns
`timescale 1ns/1ps
`default_nettype none
module vism_core_model #(
  parameter int DELAY = 4
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       vec_valid,
  input  wire logic       vec_is_sp,
  input  wire logic [5:0] vec_exc_num,
  output logic            exc_return
);
  int          cnt;
  logic [31:0] entry;
  // Handler entry as software stores it, mode bit set
  assign entry = {24'h0, vec_exc_num, 2'h1};
  // ==========
  // Handler run, then one return pulse
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt        <= 0;
      exc_return <= 1'b0;
    end
    else
    begin
      exc_return <= (cnt == 1);
      if (vec_valid && !vec_is_sp && vec_exc_num > 6'h01 && entry[0])
        cnt <= DELAY;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule : vism_core_model
`default_nettype wire

// ### src/vism_arbiter.sv
// Priority arbiter over exception numbers
`timescale 1ns/1ps
`default_nettype none
module vism_arbiter #(
  parameter int N = vism_pkg::NUM_EXC
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [N-1:0]                  req,
  input  wire logic [N*vism_pkg::PRIO_W-1:0] prio_flat,
  input  wire logic [1:0]                    prio_group,
  output logic                               found,
  output logic      [5:0]                    num,
  output logic      [vism_pkg::RANK_W-1:0]   grp
);
  import vism_pkg::*;

  logic [RANK_W+PRIO_W-1:0] key [N];
  logic [RANK_W+PRIO_W-1:0] best_key;
  logic [N-1:0]             lower;

  // ==========================================================
  // Sort key: group rank then subpriority
  for (genvar i = 0; i < N; i++) begin : g_key
    logic [2:0] p;
    assign p = prio_flat[i*PRIO_W +: PRIO_W];
    if (i == EXC_RESET) begin : g_rst
      assign key[i] = {RANK_RESET, 3'h0};
    end
    else if (i == EXC_NMI) begin : g_nmi
      assign key[i] = {RANK_NMI, 3'h0};
    end
    else if (i == EXC_HARD) begin : g_hf
      assign key[i] = {RANK_HARD, 3'h0};
    end
    else begin : g_prog
      assign key[i] = {RANK_PROG_BASE | {2'b00, p >> prio_group}, p & ~(3'h7 << prio_group)};
    end
    assign lower[i] = found && req[i] && (6'(i) < num) && (key[i] <= best_key);
  end

  // ==========================================================
  // Lowest key wins, lowest number breaks ties
  always_comb
  begin
    found    = 1'b0;
    best_key = '1;
    num      = EXC_NONE;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!found || key[i] < best_key)) begin
        found    = 1'b1;
        best_key = key[i];
        num      = 6'(i);
      end
    end
    grp = best_key[RANK_W+PRIO_W-1:PRIO_W];
  end

  property p_tie_low;
    @(posedge clk) disable iff (!nrst)
      found |-> (lower == '0) && req[num];
  endproperty
  a_tie_low: assert property (p_tie_low)
    else $error("a lower numbered equal request was passed over");
endmodule : vism_arbiter
`default_nettype wire

// ### src/vism_src_sel.sv
// Per-vector source selector
`timescale 1ns/1ps
`default_nettype none
module vism_src_sel (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [vism_pkg::NUM_IRQ-1:0] fixed_irq,
  input  wire logic [15:0]                  dma_term_out_low,
  input  wire logic [15:0]                  dma_term_out_high,
  input  wire logic [vism_pkg::NUM_IRQ-1:0] fabric_irq,
  input  wire logic [2*vism_pkg::NUM_IRQ-1:0] src_sel,
  output logic      [vism_pkg::NUM_IRQ-1:0] irq_req
);
  import vism_pkg::*;

  // ==========================================================
  // Selector per vector
  for (genvar v = 0; v < NUM_IRQ; v++) begin : g_vec
    logic [1:0] sel;
    logic       dma_bit;
    logic       fixed_bit;
    assign sel = src_sel[2*v +: 2];
    if (v < DMA_HALF) begin : g_lo
      assign dma_bit = dma_term_out_low[v];
    end
    else begin : g_hi
      assign dma_bit = dma_term_out_high[v-DMA_HALF];
    end
    assign fixed_bit = fixed_irq[v] & ~FIXED_RSV_MASK[v];
    always_comb
    begin
      case (sel)
        SRC_FIXED:  irq_req[v] = fixed_bit;
        SRC_DMA:    irq_req[v] = dma_bit;
        SRC_FABRIC: irq_req[v] = fabric_irq[v];
        default:    irq_req[v] = 1'b0;
      endcase
    end

    property p_src_fabric;
      @(posedge clk) disable iff (!nrst)
        (sel == SRC_FABRIC) |-> (irq_req[v] == fabric_irq[v]) && (sel != SRC_NONE);
    endproperty
    a_src_fabric: assert property (p_src_fabric)
      else $error("fabric source not routed to its vector");
  end
endmodule : vism_src_sel
`default_nettype wire

// ### src/vism_top.sv
// Vectored interrupt controller with per-vector source selection
`timescale 1ns/1ps
`default_nettype none
module vism_top #(
  parameter int NMI_PINS  = 64,
  parameter int NMI_SEL_W = 6
) (
  input  wire logic                             clk,
  input  wire logic                             nrst,
  input  wire logic [vism_pkg::NUM_IRQ-1:0]     fixed_irq,
  input  wire logic [15:0]                      dma_term_out_low,
  input  wire logic [15:0]                      dma_term_out_high,
  input  wire logic [vism_pkg::NUM_IRQ-1:0]     fabric_irq,
  input  wire logic [2*vism_pkg::NUM_IRQ-1:0]   src_sel,
  input  wire logic [vism_pkg::NUM_IRQ-1:0]     irq_enable,
  input  wire logic [3*vism_pkg::NUM_IRQ-1:0]   irq_prio,
  input  wire logic [20:0]                      sys_prio,
  input  wire logic [1:0]                       prio_group,
  input  wire logic [2:0]                       fault_en,
  input  wire logic                             memory_mgmt_fault_evt,
  input  wire logic                             bus_err_prefetch,
  input  wire logic                             bus_err_data,
  input  wire logic                             usage_undef_instr,
  input  wire logic                             usage_state_exit,
  input  wire logic                             supervisor_call_req,
  input  wire logic                             deferred_service_request_set,
  input  wire logic                             system_tick_timer_evt,
  input  wire logic                             debug_mon_req,
  input  wire logic [NMI_PINS-1:0]              nmi_pins,
  input  wire logic [NMI_SEL_W-1:0]             nmi_pin_sel,
  input  wire logic                             nmi_connect,
  input  wire logic                             exc_return,
  output logic                                  vec_valid,
  output logic                                  vec_is_sp,
  output logic      [9:0]                       vec_offset,
  output logic      [5:0]                       vec_exc_num,
  output logic                                  stack_push,
  output logic                                  stack_pop,
  output logic      [vism_pkg::CNT_W-1:0]       stack_word,
  output logic      [5:0]                       active_exc
);
  import vism_pkg::*;

  vism_state_t                st_reg;
  vism_state_t                st_next;
  logic [CNT_W-1:0]           cnt_reg;
  logic [5:0]                 sel_reg;
  logic [RANK_W-1:0]          sel_grp_reg;
  logic [NUM_EXC-1:0]         pend_reg;
  logic [NUM_EXC-1:0]         pend_set;
  logic [NUM_EXC-1:0]         pend_clr;
  logic [NUM_EXC-1:0]         active_reg;
  logic [NUM_EXC-1:0]         act_set;
  logic [NUM_EXC-1:0]         act_clr;
  logic [NUM_EXC*PRIO_W-1:0]  prio_flat;
  logic [NUM_IRQ-1:0]         irq_req;
  logic                       best_found;
  logic [5:0]                 best_num;
  logic [RANK_W-1:0]          best_grp;
  logic                       cur_found;
  logic [5:0]                 cur_num;
  logic [RANK_W-1:0]          cur_grp;
  logic [RANK_W-1:0]          exec_grp;
  logic                       preempt;
  logic                       nmi_line;
  logic                       nmi_prev_reg;
  logic                       nmi_rise;
  logic                       mem_ok;
  logic                       bus_ok;
  logic                       use_ok;
  logic                       mem_evt;
  logic                       bus_evt;
  logic                       use_evt;
  logic                       vec_valid_reg;
  logic                       vec_is_sp_reg;
  logic [9:0]                 vec_offset_reg;
  logic [5:0]                 vec_exc_num_reg;
  logic                       stack_push_reg;
  logic                       stack_pop_reg;
  logic [CNT_W-1:0]           stack_word_reg;
  logic [5:0]                 active_exc_reg;

  // ==========================================================
  // Group rank of a programmable priority
  function automatic logic [RANK_W-1:0] grp_of(input logic [PRIO_W-1:0] p, input logic [1:0] g);
    return RANK_PROG_BASE | {2'b00, p >> g};
  endfunction : grp_of

  // ==========================================================
  // Sources and arbitration
  vism_src_sel u_src (
    .clk               (clk),
    .nrst              (nrst),
    .fixed_irq         (fixed_irq),
    .dma_term_out_low  (dma_term_out_low),
    .dma_term_out_high (dma_term_out_high),
    .fabric_irq        (fabric_irq),
    .src_sel           (src_sel),
    .irq_req           (irq_req)
  );

  always_comb
  begin
    prio_flat                                   = '0;
    prio_flat[EXC_MEM*PRIO_W +: PRIO_W]         = sys_prio[0 +: PRIO_W];
    prio_flat[EXC_BUS*PRIO_W +: PRIO_W]         = sys_prio[3 +: PRIO_W];
    prio_flat[EXC_USAGE*PRIO_W +: PRIO_W]       = sys_prio[6 +: PRIO_W];
    prio_flat[EXC_SUPV*PRIO_W +: PRIO_W]        = sys_prio[9 +: PRIO_W];
    prio_flat[EXC_DEBUG*PRIO_W +: PRIO_W]       = sys_prio[12 +: PRIO_W];
    prio_flat[EXC_DSR*PRIO_W +: PRIO_W]         = sys_prio[15 +: PRIO_W];
    prio_flat[EXC_TICK*PRIO_W +: PRIO_W]        = sys_prio[18 +: PRIO_W];
    prio_flat[NUM_EXC*PRIO_W-1:NUM_SYS*PRIO_W]  = irq_prio;
  end

  vism_arbiter #(
    .N (NUM_EXC)
  ) u_pend_arb (
    .clk        (clk),
    .nrst       (nrst),
    .req        (pend_reg & ~active_reg),
    .prio_flat  (prio_flat),
    .prio_group (prio_group),
    .found      (best_found),
    .num        (best_num),
    .grp        (best_grp)
  );

  vism_arbiter #(
    .N (NUM_EXC)
  ) u_act_arb (
    .clk        (clk),
    .nrst       (nrst),
    .req        (active_reg),
    .prio_flat  (prio_flat),
    .prio_group (prio_group),
    .found      (cur_found),
    .num        (cur_num),
    .grp        (cur_grp)
  );

  assign exec_grp = cur_found ? cur_grp : RANK_THREAD;
  assign preempt  = best_found && (best_grp < exec_grp);

  // ==========================================================
  // Non-maskable input and fault escalation
  assign nmi_line = nmi_connect && (32'(nmi_pin_sel) < NMI_PINS) && nmi_pins[nmi_pin_sel];
  assign nmi_rise = nmi_line & ~nmi_prev_reg;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      nmi_prev_reg <= 1'b0;
    else
      nmi_prev_reg <= nmi_line;
  end

  assign mem_evt = memory_mgmt_fault_evt;
  assign bus_evt = bus_err_prefetch | bus_err_data;
  assign use_evt = usage_undef_instr | usage_state_exit;
  assign mem_ok  = fault_en[0] && (grp_of(sys_prio[0 +: PRIO_W], prio_group) < exec_grp);
  assign bus_ok  = fault_en[1] && (grp_of(sys_prio[3 +: PRIO_W], prio_group) < exec_grp);
  assign use_ok  = fault_en[2] && (grp_of(sys_prio[6 +: PRIO_W], prio_group) < exec_grp);

  // ==========================================================
  // Pending state
  always_comb
  begin
    pend_set                        = '0;
    pend_set[EXC_NMI]               = nmi_rise;
    pend_set[EXC_HARD]              = (mem_evt & ~mem_ok) | (bus_evt & ~bus_ok) | (use_evt & ~use_ok);
    pend_set[EXC_MEM]               = mem_evt & mem_ok;
    pend_set[EXC_BUS]               = bus_evt & bus_ok;
    pend_set[EXC_USAGE]             = use_evt & use_ok;
    pend_set[EXC_SUPV]              = supervisor_call_req;
    pend_set[EXC_DEBUG]             = debug_mon_req;
    pend_set[EXC_DSR]               = deferred_service_request_set;
    pend_set[EXC_TICK]              = system_tick_timer_evt;
    pend_set[NUM_EXC-1:NUM_SYS]     = irq_req & irq_enable;
    pend_set                        = pend_set & ~RSV_EXC_MASK;
    pend_clr                        = (st_reg == ST_VECTOR) ? (48'h1 << sel_reg) : '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pend_reg <= '0;
    else
      pend_reg <= (pend_reg & ~pend_clr) | pend_set;
  end

  // ==========================================================
  // Active state
  assign act_set = (st_reg == ST_VECTOR) ? (48'h1 << sel_reg) : '0;
  assign act_clr = (st_reg == ST_HANDLER && exc_return && cur_found) ? (48'h1 << cur_num) : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      active_reg <= '0;
    else
      active_reg <= (active_reg & ~act_clr) | act_set;
  end

  // ==========================================================
  // Entry and exit sequencer
  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ST_BOOT_SP: st_next = ST_BOOT_PC;
      ST_BOOT_PC: st_next = ST_IDLE;
      ST_IDLE:
        if (preempt)
          st_next = ST_STACK;
      ST_STACK:
        if (cnt_reg == CNT_LAST)
          st_next = ST_VECTOR;
      ST_VECTOR:  st_next = ST_HANDLER;
      ST_HANDLER:
        if (exc_return)
          st_next = ST_RETCHK;
        else if (preempt)
          st_next = ST_STACK;
      ST_RETCHK:  st_next = preempt ? ST_VECTOR : ST_UNSTACK;
      ST_UNSTACK:
        if (cnt_reg == CNT_LAST)
          st_next = cur_found ? ST_HANDLER : ST_IDLE;
      default:    st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= ST_BOOT_SP;
    else
      st_reg <= st_next;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (st_reg == ST_STACK || st_reg == ST_UNSTACK)
      cnt_reg <= cnt_reg + 3'h1;
    else
      cnt_reg <= '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_reg     <= EXC_NONE;
      sel_grp_reg <= RANK_THREAD;
    end
    else if ((st_reg == ST_IDLE || st_reg == ST_HANDLER || st_reg == ST_RETCHK) && preempt)
    begin
      sel_reg     <= best_num;
      sel_grp_reg <= best_grp;
    end
    else if (st_reg == ST_STACK && best_found && best_grp < sel_grp_reg)
    begin
      sel_reg     <= best_num;
      sel_grp_reg <= best_grp;
    end
  end

  // ==========================================================
  // Core-facing outputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vec_valid_reg   <= 1'b0;
      vec_is_sp_reg   <= 1'b0;
      vec_offset_reg  <= OFS_SP;
      vec_exc_num_reg <= EXC_NONE;
      stack_push_reg  <= 1'b0;
      stack_pop_reg   <= 1'b0;
      stack_word_reg  <= '0;
      active_exc_reg  <= EXC_NONE;
    end
    else
    begin
      vec_valid_reg  <= (st_reg == ST_BOOT_SP) || (st_reg == ST_BOOT_PC) || (st_reg == ST_VECTOR);
      vec_is_sp_reg  <= (st_reg == ST_BOOT_SP);
      if (st_reg == ST_BOOT_SP)
      begin
        vec_offset_reg  <= OFS_SP;
        vec_exc_num_reg <= EXC_NONE;
      end
      else if (st_reg == ST_BOOT_PC)
      begin
        vec_offset_reg  <= OFS_RESET;
        vec_exc_num_reg <= EXC_RESET;
      end
      else if (st_reg == ST_VECTOR)
      begin
        vec_offset_reg  <= {2'b00, sel_reg, 2'b00};
        vec_exc_num_reg <= sel_reg;
      end
      stack_push_reg <= (st_reg == ST_STACK);
      stack_pop_reg  <= (st_reg == ST_UNSTACK);
      stack_word_reg <= cnt_reg;
      active_exc_reg <= cur_found ? cur_num : EXC_NONE;
    end
  end

  assign vec_valid   = vec_valid_reg;
  assign vec_is_sp   = vec_is_sp_reg;
  assign vec_offset  = vec_offset_reg;
  assign vec_exc_num = vec_exc_num_reg;
  assign stack_push  = stack_push_reg;
  assign stack_pop   = stack_pop_reg;
  assign stack_word  = stack_word_reg;
  assign active_exc  = active_exc_reg;

  // ==========================================================
  // Checks
  property p_vec_ofs;
    @(posedge clk) disable iff (!nrst)
      vec_valid && !vec_is_sp |-> (vec_offset == {2'b00, vec_exc_num, 2'b00}) && (vec_exc_num != EXC_NONE);
  endproperty
  a_vec_ofs: assert property (p_vec_ofs)
    else $error("vector offset differs from four times number");

  property p_boot;
    @(posedge clk) disable iff (!nrst)
      vec_is_sp |-> (vec_offset == OFS_SP) ##1 (vec_valid && !vec_is_sp && vec_offset == OFS_RESET);
  endproperty
  a_boot: assert property (p_boot)
    else $error("reset vector does not follow stack pointer word");

  property p_escalate;
    @(posedge clk) disable iff (!nrst)
      memory_mgmt_fault_evt && !fault_en[0] |=> pend_reg[EXC_HARD] && !$rose(pend_reg[EXC_MEM]);
  endproperty
  a_escalate: assert property (p_escalate)
    else $error("disabled fault did not escalate");

  property p_nmi_conn;
    @(posedge clk) disable iff (!nrst)
      $rose(pend_reg[EXC_NMI]) |-> $past(nmi_connect);
  endproperty
  a_nmi_conn: assert property (p_nmi_conn)
    else $error("nmi pended while disconnected");

  property p_tail;
    @(posedge clk) disable iff (!nrst)
      (st_reg == ST_RETCHK) && preempt |=> (st_reg == ST_VECTOR) ##1 vec_valid && !stack_pop;
  endproperty
  a_tail: assert property (p_tail)
    else $error("tail chain did not go straight to vector");

  property p_push;
    @(posedge clk) disable iff (!nrst)
      $rose(st_reg == ST_STACK) |=> stack_push[*8] ##1 vec_valid;
  endproperty
  a_push: assert property (p_push)
    else $error("entry push sequence wrong length");

  property p_rsv;
    @(posedge clk) disable iff (!nrst)
      (pend_reg & RSV_EXC_MASK) == '0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved exception number pended");
endmodule : vism_top
`default_nettype wire
